// file: dv/cmp_analog_model.sv
// Purpose: Comparator stand-in at the far side of the PWM core
// Assumes: Sensed current ramps only while the gate is on
// Notes:   A trip setting of zero means that comparator never fires
`timescale 1ns/1ps
module cmp_analog_model (
   input  wire logic       i_clk,    // Reference clock
   input  wire logic       i_gate,   // Gate drive from the core
   input  wire logic [9:0] i_fb_at,  // Feedback trip, gate cycles
   input  wire logic [9:0] i_ss_at,  // Soft start trip, gate cycles
   input  wire logic [9:0] i_pk_at,  // Peak trip, gate cycles
   input  wire logic [9:0] i_bl_at,  // Burst trip, gate cycles
   output logic            o_fb,     // Feedback comparator
   output logic            o_ss,     // Soft start comparator
   output logic            o_pk,     // Peak limit comparator
   output logic            o_bl      // Burst limit comparator
);
   logic [9:0] on_cnt_r;  // Gate-high cycles in this pulse

   function automatic logic trip(input logic [9:0] at, input logic [9:0] n);
      return (at != 10'h000) && (n >= at);
   endfunction : trip

   //------------------------------------------------------------
   // Ramp and comparators
   //------------------------------------------------------------
   initial begin
      on_cnt_r = 10'h000;
      {o_fb, o_ss, o_pk, o_bl} = 4'h0;
   end
   // Current falls to zero with the gate, so every trip drops too
   always @(posedge i_clk) begin
      on_cnt_r <= i_gate ? on_cnt_r + 10'h001 : 10'h000;
      o_fb     <= i_gate && trip(i_fb_at, on_cnt_r);
      o_ss     <= i_gate && trip(i_ss_at, on_cnt_r);
      o_pk     <= i_gate && trip(i_pk_at, on_cnt_r);
      o_bl     <= i_gate && trip(i_bl_at, on_cnt_r);
   end
endmodule : cmp_analog_model

// file: dv/current_mode_pwm_softstart_tb.sv
// Purpose: Self-checking bench of the PWM core
// Assumes: Short soft start counts; partner ramps while gate is on
// Notes:   Inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module current_mode_pwm_softstart_tb;
   import cmp_pkg::*;
   localparam int STEP = 100;  // Cycles per soft start step
   localparam int TOT  = 3200; // Soft start length, cycles
   logic       i_clk, i_rst, i_burst_mode, i_supply_ok, i_restart;
   logic       fb, ss, pk, bl, o_gate, o_blanking, o_ss_sink_en, o_ss_done;
   logic [4:0] o_ss_level;
   logic [9:0] fb_at, ss_at, pk_at, bl_at;
   int         n_mismatch, checked, cyc, on_t, per_t, blk_t, t0, k;

   cmp_core #(.SS_STEP(STEP), .SS_TOT(TOT)) DUT (
      .i_clk(i_clk), .i_rst(i_rst), .i_fb_cmp(fb), .i_ss_cmp(ss),
      .i_peak_cmp(pk), .i_burst_cmp(bl), .i_burst_mode(i_burst_mode),
      .i_supply_ok(i_supply_ok), .i_restart(i_restart), .o_gate(o_gate),
      .o_blanking(o_blanking), .o_ss_sink_en(o_ss_sink_en),
      .o_ss_level(o_ss_level), .o_ss_done(o_ss_done));
   cmp_analog_model u_ana (
      .i_clk(i_clk), .i_gate(o_gate), .i_fb_at(fb_at), .i_ss_at(ss_at),
      .i_pk_at(pk_at), .i_bl_at(bl_at), .o_fb(fb), .o_ss(ss),
      .o_pk(pk), .o_bl(bl));

   //------------------------------------------------------------
   // Clock and cycle count
   //------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) cyc++;

   //------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   // Range check reports the lower bound as the expected value; an
   // unknown value is never taken as in range
   task automatic check_in(input string what, input integer v,
                           input int lo, input int hi);
      check(what, v, ((v >= lo && v <= hi) === 1'b1) ? v : lo);
   endtask : check_in

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : step

   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_val(ref logic s, input logic v, input int lim);
      for (k = 0; k < lim && s !== v; k++) step(1);
      if (s !== v) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wait_val

   task automatic trips(input logic [9:0] f, s, p, b);
      {fb_at, ss_at, pk_at, bl_at} = {f, s, p, b};
   endtask : trips

   // On time, blanking width and period of the next gate pulse
   task automatic pulse();
      wait_val(o_gate, 1'b1, 2000);
      {on_t, blk_t} = 0;
      while (o_gate === 1'b1 && on_t < 600) begin
         blk_t += int'(o_blanking === 1'b1);
         on_t++;
         step(1);
      end
      per_t = on_t;
      while (o_gate !== 1'b1 && per_t < 1200) begin
         per_t++;
         step(1);
      end
      // A stuck gate uses up a bound and ends the run as a mismatch
      if (on_t >= 600 || per_t >= 1200) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : pulse

   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic sc_supply_low();
      check("idle outs", {o_gate, o_ss_sink_en, o_ss_level, o_ss_done},
            32'h0);
      for (t0 = 0; t0 < 1000; t0++) begin
         if (o_gate !== 1'b0) check("gate low", o_gate, 32'h0);
         step(1);
      end
   endtask : sc_supply_low

   task automatic sc_start();
      int ramp0;
      i_supply_ok = 1'b1;
      wait_val(o_ss_sink_en, 1'b1, 8);
      check("start level", o_ss_level, 32'h0);
      for (k = 0; k < 2 * STEP && o_ss_level !== 5'h01; k++) step(1);
      t0 = cyc;
      for (k = 0; k < 2 * STEP && o_ss_level !== 5'h02; k++) step(1);
      check("step gap", cyc - t0, STEP);
      t0 = cyc - 2 * STEP;
      // Both pulses fall early in the ramp, well below the duty limit
      pulse();
      check_in("ramp on", on_t, 9, 359);
      ramp0 = on_t;
      pulse();
      check_in("ramp grows", on_t, ramp0 + 1, 359);
      check("ramp period", per_t, PER_CYC);
      wait_val(o_ss_done, 1'b1, TOT);
      check_in("ss length", cyc - t0, TOT - 3, TOT + 3);
      check("sink off", o_ss_sink_en, 32'h0);
      check("last step", o_ss_level, 32'h1F);
   endtask : sc_start

   task automatic sc_normal();
      int p0;
      int moved;
      pulse();
      p0 = per_t;
      moved = 0;
      for (int i = 0; i < 12; i++) begin
         pulse();
         check_in("period", per_t, 480, 520);
         check_in("duty cap", on_t * 4, per_t * 3 - 8, per_t * 3);
         moved += int'(per_t != p0);
      end
      check_in("sweep", moved, 1, 12);
   endtask : sc_normal

   task automatic sc_clear();
      for (int c = 0; c < 3; c++) begin
         trips(c == 0 ? 10'h03C : 10'h000, c == 1 ? 10'h03C : 10'h000,
               c == 2 ? 10'h03C : 10'h000, 10'h000);
         pulse();
         pulse();
         check_in("cmp clear", on_t, 60, 66);
      end
      trips(10'h000, 10'h000, 10'h000, 10'h03C);
      pulse();
      pulse();
      check_in("burst off", on_t, 300, 400);
      i_burst_mode = 1'b1;
      pulse();
      pulse();
      check_in("burst on", on_t, 60, 66);
   endtask : sc_clear

   task automatic sc_blank();
      for (int b = 0; b < 2; b++) begin
         i_burst_mode = b[0];
         trips(10'h000, 10'h000, 10'h001, 10'h000);
         pulse();
         pulse();
         check("blank len", blk_t, b ? BLK_B_CYC : BLK_N_CYC);
         check_in("blank hold", on_t, b ? 9 : 11, b ? 13 : 15);
         trips(10'h001, 10'h000, 10'h000, 10'h000);
         pulse();
         pulse();
         check_in("min on", on_t, 8, 15);
      end
      i_burst_mode = 1'b0;
      trips(10'h000, 10'h000, 10'h000, 10'h000);
   endtask : sc_blank

   task automatic sc_restart();
      i_restart = 1'b1;
      step(3);
      i_restart = 1'b0;
      wait_val(o_ss_done, 1'b0, 8);
      check("rerun sink", o_ss_sink_en, 32'h1);
      check_in("rerun lvl", o_ss_level, 0, 1);
      wait_val(o_ss_done, 1'b1, TOT + 10);
   endtask : sc_restart

   task automatic sc_drop();
      pulse();
      step(30);
      i_supply_ok = 1'b0;
      step(4);
      check("drop outs", {o_gate, o_ss_sink_en, o_ss_level, o_ss_done},
            32'h0);
      step(20);
      i_supply_ok = 1'b1;
      wait_val(o_ss_sink_en, 1'b1, 8);
      check("drop lvl", o_ss_level, 32'h0);
   endtask : sc_drop

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      {i_rst, i_burst_mode, i_supply_ok, i_restart} = 4'h8;
      trips(10'h000, 10'h000, 10'h000, 10'h000);
      {n_mismatch, checked, cyc} = 0;
      step(10);
      i_rst = 1'b0;
      sc_supply_low();
      sc_start();
      sc_normal();
      sc_clear();
      sc_blank();
      sc_restart();
      sc_drop();
      tally_and_finish();
   end
endmodule : current_mode_pwm_softstart_tb

// file: rtl/cmp_core.sv
// Purpose: Pulse latch, blanking and soft start of a PWM controller
// Assumes: Comparator and supply inputs are asynchronous levels
// Notes:   Gate is registered; each clear lands one edge after sync
`timescale 1ns/1ps
module cmp_core #(
   parameter int SS_STEP = cmp_pkg::SS_STEP_CYC, // Cycles per step
   parameter int SS_TOT  = cmp_pkg::SS_TOT_CYC   // Soft start length
) (
   input  wire logic       i_clk,         // 50 MHz reference clock
   input  wire logic       i_rst,         // Synchronous, active high
   input  wire logic       i_fb_cmp,      // Feedback comparator
   input  wire logic       i_ss_cmp,      // Soft start comparator
   input  wire logic       i_peak_cmp,    // Peak limit comparator
   input  wire logic       i_burst_cmp,   // Burst limit comparator
   input  wire logic       i_burst_mode,  // Active burst mode flag
   input  wire logic       i_supply_ok,   // Supply above threshold
   input  wire logic       i_restart,     // Auto-restart attempt
   output logic            o_gate,        // Gate drive
   output logic            o_blanking,    // Blanking window active
   output logic            o_ss_sink_en,  // Soft start sink on
   output logic [4:0]      o_ss_level,    // Soft start step
   output logic            o_ss_done      // Normal operation
);
   import cmp_pkg::*;

   //--------------------------------------------------------------
   // State
   //--------------------------------------------------------------
   typedef struct packed {
      logic [IN_N-1:0] s1;        // First sync stage
      logic [IN_N-1:0] s2;        // Second sync stage
      logic            sup_d;     // Supply, one cycle late
      logic            rst_d;     // Restart, one cycle late
      cmp_ss_t         ss;
      logic [4:0]      step;
      logic [13:0]     tick;
      logic [18:0]     total;
      logic            gate;
      logic [PHW-1:0]  onc;       // Cycles since turn-on
      logic            blank;
      logic            sink;
      logic            done;
   } cmp_core_st_t;

   cmp_core_st_t r, r_nxt;
   cmp_osc_if    osc_l ();

   logic [IN_N-1:0] pins;
   logic            sup, fb, ssc, pk, bl, bm, start_ss;
   logic [PHW-1:0]  blk_len, cap;
   logic [PHW+4:0]  ramp;
   logic            in_blank, trip;

   assign pins = {i_restart, i_supply_ok, i_burst_mode, i_burst_cmp,
                  i_peak_cmp, i_ss_cmp, i_fb_cmp};

   //--------------------------------------------------------------
   // Oscillator
   //--------------------------------------------------------------
   cmp_osc u_osc (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .osc   (osc_l.osc)
   );

   // Oscillator runs only with supply; sweep after soft start
   assign osc_l.run    = (r.ss != SS_OFF);
   assign osc_l.jit_en = (r.ss == SS_RUN);

   //--------------------------------------------------------------
   // Synchronised inputs, only second stage is read
   //--------------------------------------------------------------
   assign sup = r.s2[IN_SUP];
   assign fb  = r.s2[IN_FB];
   assign ssc = r.s2[IN_SS];
   assign pk  = r.s2[IN_PK];
   assign bl  = r.s2[IN_BL];
   assign bm  = r.s2[IN_BM];

   // Soft start begins on supply rise or on a restart rising edge while supply is good
   assign start_ss = sup && (!r.sup_d
                     || (r.s2[IN_RST] && !r.rst_d));

   //--------------------------------------------------------------
   // Blanking and duty limit
   //--------------------------------------------------------------
   // Shorter window in burst, since burst pulses are small
   assign blk_len  = bm ? BLK_B_CYC : BLK_N_CYC;
   assign in_blank = r.onc < blk_len;
   // Soft start scales the limit by (step+1)/32
   assign ramp = {5'h00, osc_l.max_on} * {10'h000, r.step} +
                 {5'h00, osc_l.max_on};
   always_comb begin
      if (r.ss == SS_RAMP)
         cap = PHW'(ramp >> 5);
      else
         cap = osc_l.max_on;
      if (cap < MINON_CYC + 10'h001)
         cap = MINON_CYC + 10'h001;
   end

   // First comparator to fire outside the blanking window ends the pulse (burst one only in burst mode), after the minimum on
   // time; soft start comparator sits behind the amplifier too
   assign trip = !in_blank && (fb
                 || ssc
                 || pk
                 || (bl && bm));

   //--------------------------------------------------------------
   // Next state
   //--------------------------------------------------------------
   always_comb begin
      r_nxt       = r;
      r_nxt.s1    = pins;
      r_nxt.s2    = r.s1;
      r_nxt.sup_d = sup;
      r_nxt.rst_d = r.s2[IN_RST];
      // Soft start sequencer
      if (!sup) begin
         r_nxt.ss    = SS_OFF;
         r_nxt.step  = '0;
         r_nxt.tick  = '0;
         r_nxt.total = '0;
         r_nxt.sink  = 1'b0;
         r_nxt.done  = 1'b0;
      end else if (start_ss) begin
         r_nxt.ss    = SS_RAMP;
         r_nxt.step  = '0;
         r_nxt.tick  = '0;
         r_nxt.total = '0;
         r_nxt.sink  = 1'b1;
         r_nxt.done  = 1'b0;
      end else if (r.ss == SS_RAMP) begin
         r_nxt.total = r.total + 19'h00001;
         if (r.tick == 14'(SS_STEP - 1)) begin
            r_nxt.tick = '0;
            if (r.step != SS_LAST)
               r_nxt.step = r.step + 5'h01;
         end else begin
            r_nxt.tick = r.tick + 14'h0001;
         end
         if (r.total == 19'(SS_TOT - 1)) begin
            r_nxt.ss   = SS_RUN;
            r_nxt.sink = 1'b0;
            r_nxt.done = 1'b1;
         end
      end
      // Pulse latch
      if (!sup || r.ss == SS_OFF) begin
         r_nxt.gate = 1'b0;
         r_nxt.onc  = '0;
      end else if (osc_l.cyc_start) begin
         r_nxt.gate = 1'b1;
         r_nxt.onc  = '0;
      end else if (r.gate) begin
         r_nxt.onc = r.onc + 10'h001;
         if (r.onc >= MINON_CYC - 10'h001 &&
             (trip || r.onc + 10'h001 >= cap))
            r_nxt.gate = 1'b0;
      end
      r_nxt.blank = r_nxt.gate && (r_nxt.onc < blk_len);
   end

   //--------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '{s1: '0, s2: '0, sup_d: 1'b0, rst_d: 1'b0,
                ss: SS_OFF, step: '0, tick: '0, total: '0,
                gate: 1'b0, onc: '0, blank: 1'b0, sink: 1'b0,
                done: 1'b0};
      end else begin
         r <= r_nxt;
      end
   end

   assign o_gate       = r.gate;
   assign o_blanking   = r.blank;
   assign o_ss_sink_en = r.sink;
   assign o_ss_level   = r.step;
   assign o_ss_done    = r.done;

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_turn_on;
      !o_gate ##1 o_gate;
   endsequence

   property p_uv_off;
      !sup |=> !o_gate;
   endproperty
   a_uv_off : assert property (p_uv_off)
      else $error("gate on with supply low");

   property p_fb_end;
      o_gate && fb && !in_blank && r.onc >= MINON_CYC - 10'h001
         && !osc_l.cyc_start && sup |=> !o_gate;
   endproperty
   a_fb_end : assert property (p_fb_end)
      else $error("feedback did not end pulse");

   property p_peak_end;
      o_gate && pk && !in_blank && r.onc >= MINON_CYC - 10'h001
         && !osc_l.cyc_start && sup |=> !o_gate;
   endproperty
   a_peak_end : assert property (p_peak_end)
      else $error("peak limit did not end pulse");

   property p_burst_off;
      o_gate && !fb && !ssc && !pk && !bm
         && r.onc + 10'h001 < cap && !osc_l.cyc_start && sup
         |=> o_gate;
   endproperty
   a_burst_off : assert property (p_burst_off)
      else $error("burst limit acted outside burst mode");

   property p_min_on;
      s_turn_on |-> o_gate[*8];
   endproperty
   a_min_on : assert property (p_min_on)
      else $error("on pulse shorter than minimum");

   property p_duty;
      o_gate |-> r.onc < osc_l.max_on;
   endproperty
   a_duty : assert property (p_duty)
      else $error("on time above duty limit");

   property p_step;
      r.ss == SS_RAMP && sup && !start_ss && r.step != SS_LAST
         && r.tick == 14'(SS_STEP - 1) |=> r.step == $past(r.step) + 5'h01;
   endproperty
   a_step : assert property (p_step)
      else $error("soft start step not advanced");

   property p_ss_end;
      r.ss == SS_RAMP && sup && !start_ss
         && r.total == 19'(SS_TOT - 1) |=> !o_ss_sink_en && o_ss_done;
   endproperty
   a_ss_end : assert property (p_ss_end)
      else $error("soft start did not finish");

   property p_ss_start;
      start_ss |=> r.ss == SS_RAMP && o_ss_level == 5'h00
         && o_ss_sink_en;
   endproperty
   a_ss_start : assert property (p_ss_start)
      else $error("soft start not restarted");

   property p_uv_reset;
      !sup |=> o_ss_level == 5'h00 && !o_ss_done;
   endproperty
   a_uv_reset : assert property (p_uv_reset)
      else $error("soft start not reset on supply loss");

   // Every oscillator start sets the latch while the supply is good
   property p_set;
      osc_l.cyc_start && sup && r.ss != SS_OFF
         |=> o_gate && r.onc == 10'h000;
   endproperty
   a_set : assert property (p_set)
      else $error("oscillator start did not set latch");

   // Inside the window no comparator may end the pulse
   property p_blank_hold;
      o_gate && in_blank && r.onc + 10'h001 < cap
         && !osc_l.cyc_start && sup |=> o_gate;
   endproperty
   a_blank_hold : assert property (p_blank_hold)
      else $error("pulse ended during blanking");

   // Both window lengths cover at least the first eight cycles
   property p_blank_on;
      s_turn_on |-> o_blanking[*8];
   endproperty
   a_blank_on : assert property (p_blank_on)
      else $error("blanking missing at turn-on");

   // Neither window outlasts the longer normal-load length
   property p_blank_off;
      o_gate && r.onc >= BLK_N_CYC |-> !o_blanking;
   endproperty
   a_blank_off : assert property (p_blank_off)
      else $error("blanking longer than its window");

   // Ramp length leaves room for all steps, so normal run sits on top
   property p_ss_full;
      r.ss == SS_RUN |-> o_ss_level == SS_LAST;
   endproperty
   a_ss_full : assert property (p_ss_full)
      else $error("soft start ended below top step");
endmodule : cmp_core

// file: rtl/cmp_osc.sv
// Purpose: Switching oscillator with triangle frequency sweep
// Assumes: run and jit_en come from registers on the same clock
// Notes:   Period moves one cycle every few periods, +-JIT_DEV
`timescale 1ns/1ps
module cmp_osc (
   input  wire logic i_clk,      // Reference clock
   input  wire logic i_rst,      // Synchronous reset
   cmp_osc_if.osc    osc         // Oscillator link
);
   import cmp_pkg::*;

   typedef struct packed {
      logic [PHW-1:0] phase;
      logic [PHW-1:0] len;
      logic [5:0]     off;       // Signed period offset
      logic           up;
      logic [7:0]     pcnt;
      logic           start;
      logic [PHW-1:0] max_on;
   } cmp_osc_st_t;

   cmp_osc_st_t r, r_nxt;
   logic [PHW+1:0] prod;

   //--------------------------------------------------------------
   // Period, sweep and duty limit
   //--------------------------------------------------------------
   always_comb begin
      r_nxt       = r;
      r_nxt.start = 1'b0;
      prod        = {2'b00, r.len} * 12'(DMAX_NUM);
      if (!osc.run) begin
         r_nxt.phase = '0;
         r_nxt.off   = '0;
         r_nxt.len   = PER_CYC;
      end else if (r.phase == r.len - 10'h001) begin
         r_nxt.phase = '0;
         r_nxt.start = 1'b1;
         // Sweep only once normal operation has begun
         if (!osc.jit_en) begin
            r_nxt.off = '0;
            r_nxt.pcnt = '0;
         end else if (r.pcnt == 8'(JIT_EVERY - 1)) begin
            r_nxt.pcnt = '0;
            r_nxt.off  = r.up ? r.off + 6'h01 : r.off - 6'h01;
            if (r.up && r.off == 6'(JIT_DEV - 1))
               r_nxt.up = 1'b0;
            else if (!r.up && r.off == 6'(-(JIT_DEV - 1)))
               r_nxt.up = 1'b1;
         end else begin
            r_nxt.pcnt = r.pcnt + 8'h01;
         end
         r_nxt.len = PER_CYC + {{4{r_nxt.off[5]}}, r_nxt.off};
      end else begin
         r_nxt.phase = r.phase + 10'h001;
      end
      // Duty limit tracks the period in force
      r_nxt.max_on = PHW'(prod / 12'(DMAX_DEN));
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '{phase: '0, len: PER_CYC, off: '0, up: 1'b1,
                pcnt: '0, start: 1'b0, max_on: '0};
      end else begin
         r <= r_nxt;
      end
   end

   assign osc.cyc_start = r.start;
   assign osc.max_on    = r.max_on;

   // Without sweep, the period stays at its nominal length
   property p_osc_nominal;
      @(posedge i_clk) disable iff (i_rst)
      osc.run && !osc.jit_en && r_nxt.start |=> r.len == PER_CYC;
   endproperty
   a_osc_nominal : assert property (p_osc_nominal)
      else $error("period not nominal without sweep");
endmodule : cmp_osc

// file: rtl/cmp_osc_if.sv
// Purpose: Link between oscillator and pulse core
// Assumes: Single clock domain
// Notes:   Oscillator drives cycle start and duty limit
`timescale 1ns/1ps
interface cmp_osc_if;
   logic       cyc_start;   // One-cycle pulse per switching period
   logic [9:0] max_on;      // On-time limit of current period
   logic       run;         // Oscillator enabled
   logic       jit_en;      // Frequency sweep enabled
   modport osc  (output cyc_start, max_on, input run, jit_en);
   modport core (input cyc_start, max_on, output run, jit_en);
endinterface : cmp_osc_if

// file: rtl/cmp_pkg.sv
// Purpose: Shared constants of the current mode PWM core
// Assumes: 50 MHz reference clock
// Notes:   Times are kept in their own unit; counts derive from them
package cmp_pkg;
   //--------------------------------------------------------------
   // Clock and oscillator
   //--------------------------------------------------------------
   localparam int CLK_HZ     = 50_000_000;
   localparam int CLK_NS     = 20;
   localparam int OSC_HZ     = 100_000;
   localparam int JIT_HZ     = 4_000;
   localparam int JIT_PER_US = 4_000;
   localparam int DMAX_NUM   = 3;       // Duty limit 0.75 = 3/4
   localparam int DMAX_DEN   = 4;
   localparam int PHW        = 10;      // Phase counter width
   localparam logic [PHW-1:0] PER_CYC = PHW'(CLK_HZ / OSC_HZ);
   localparam int JIT_DEV    = (CLK_HZ / OSC_HZ) * JIT_HZ / OSC_HZ;
   // Periods between one-cycle jitter steps (triangle sweep)
   localparam int JIT_EVERY  =
      (JIT_PER_US * (OSC_HZ / 1000) / 1000) / 2 / (2 * JIT_DEV);
   //--------------------------------------------------------------
   // Pulse timing, least times rounded up
   //--------------------------------------------------------------
   localparam int MINON_NS   = 156;
   localparam int BLK_N_NS   = 220;
   localparam int BLK_B_NS   = 180;
   localparam logic [PHW-1:0] MINON_CYC =
      PHW'((MINON_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [PHW-1:0] BLK_N_CYC =
      PHW'((BLK_N_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [PHW-1:0] BLK_B_CYC =
      PHW'((BLK_B_NS + CLK_NS - 1) / CLK_NS);
   //--------------------------------------------------------------
   // Soft start
   //--------------------------------------------------------------
   localparam int SS_STEPS    = 32;
   localparam int SS_STEP_US  = 300;
   localparam int SS_TOTAL_MS = 10;
   localparam int SS_STEP_CYC = SS_STEP_US * (CLK_HZ / 1_000_000);
   localparam int SS_TOT_CYC  = SS_TOTAL_MS * (CLK_HZ / 1_000);
   localparam logic [4:0] SS_LAST = 5'(SS_STEPS - 1);
   //--------------------------------------------------------------
   // Synchroniser bit positions
   //--------------------------------------------------------------
   localparam int IN_FB   = 0;
   localparam int IN_SS   = 1;
   localparam int IN_PK   = 2;
   localparam int IN_BL   = 3;
   localparam int IN_BM   = 4;
   localparam int IN_SUP  = 5;
   localparam int IN_RST  = 6;
   localparam int IN_N    = 7;
   typedef enum logic [1:0] {SS_OFF, SS_RAMP, SS_RUN} cmp_ss_t;
endpackage : cmp_pkg
